// ===== verilog/fmr_pkg.sv
// Register map, field layout and carrier types of the fault monitor
package fmr_pkg;

  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_WDT_LOAD = 8'h04;
  localparam logic [7:0] REG_WDT_KICK = 8'h08;
  localparam logic [7:0] REG_RST_CAUSE = 8'h0C;
  localparam logic [7:0] REG_EXC_STATUS = 8'h10;
  localparam logic [7:0] REG_EXC_CLEAR = 8'h14;
  localparam logic [7:0] REG_EXC_ENABLE = 8'h18;
  localparam logic [7:0] REG_HV_STATUS = 8'h1C;
  localparam logic [7:0] REG_SENS_EN = 8'h20;
  localparam logic [7:0] REG_SP_BASE = 8'h24;
  localparam logic [7:0] REG_SP_STEP = 8'h08;
  localparam logic [7:0] REG_SP_HI = 8'h04;

  // ****************************************
  // Control fields
  // ****************************************
  localparam int CTRL_DREAD_BIT = 0;
  localparam int CTRL_WDT_EN_BIT = 1;
  localparam int CTRL_WDT_RST_BIT = 2;
  localparam int CTRL_W = 3;
  localparam logic [CTRL_W-1:0] CTRL_RST = 3'h0;

  // ****************************************
  // Exception status bits
  // ****************************************
  localparam int EXC_SENSOR = 0;
  localparam int EXC_NVM_ECC = 1;
  localparam int EXC_STACK0 = 2;
  localparam int EXC_ARITH = 5;
  localparam int EXC_CIPHER = 6;
  localparam int EXC_WDT = 7;
  localparam int EXC_DREAD = 8;
  localparam int EXC_W = 9;

  // ****************************************
  // Reset cause codes
  // ****************************************
  localparam int CAUSE_W = 4;
  localparam logic [CAUSE_W-1:0] CAUSE_NONE = 4'h0;
  localparam logic [CAUSE_W-1:0] CAUSE_POWERON = 4'h1;
  localparam logic [CAUSE_W-1:0] CAUSE_SENSOR = 4'h2;
  localparam logic [CAUSE_W-1:0] CAUSE_RAM_PAR = 4'h3;
  localparam logic [CAUSE_W-1:0] CAUSE_SCAN_PAR = 4'h4;
  localparam logic [CAUSE_W-1:0] CAUSE_ROM_PAR = 4'h5;
  localparam logic [CAUSE_W-1:0] CAUSE_WDT = 4'h6;

  // ****************************************
  // High-voltage check, memories, stack, watchdog
  // ****************************************
  localparam int HV_VALID_BIT = 0;
  localparam int HV_OK_BIT = 1;
  localparam int HV_W = 2;
  localparam int MEM_DW = 32;
  localparam int MEM_PW = 4;
  localparam int MEM_LW = MEM_DW / MEM_PW;
  localparam int SP_W = 16;
  localparam int N_PRIV = 3;
  localparam logic [SP_W-1:0] SP_LO_RST = 16'h0000;
  localparam logic [SP_W-1:0] SP_HI_RST = 16'hFFFF;
  localparam logic [31:0] WDT_LOAD_RST = 32'h0000_FFFF;

  typedef enum logic [1:0] {PRIV_USER, PRIV_SYSTEM, PRIV_SUPER} fmr_priv_type;

  typedef struct packed {
    logic valid;
    logic [MEM_DW-1:0] data;
    logic [MEM_PW-1:0] par;
  } fmr_mem_rd_type;

  typedef struct packed {
    logic valid;
    fmr_priv_type priv;
    logic [SP_W-1:0] value;
  } fmr_sp_wr_type;

  // Feedback taps of a maximal shift register, widths 8 to 12
  function automatic logic [15:0] lfsr_taps(input int aw);
    case (aw)
      8: return 16'h00B8;
      9: return 16'h0110;
      10: return 16'h0240;
      11: return 16'h0500;
      default: return 16'h0829;
    endcase
  endfunction

endpackage

// ===== verilog/fmr_scan.sv
// Background RAM parity scanner address generator
`timescale 1ns/100ps
module fmr_scan #(
  parameter int AW = 10
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // RAM arbitration
  input wire logic cpu_ram_busy,
  output logic scan_req,
  output logic [AW-1:0] scan_addr
);

  // ****************************************
  // Elaboration check
  // ****************************************
  if (AW < 8 || AW > 12)
  begin : g_bad_aw
    $error("fmr_scan: AW must lie between 8 and 12");
  end

  localparam logic [15:0] TAPS = fmr_pkg::lfsr_taps(AW);

  logic [AW-1:0] lfsr_r;
  logic [AW-1:0] lfsr_nxt;
  logic fb;

  // Only steal idle RAM cycles, never stall software
  assign scan_req = !cpu_ram_busy;
  assign scan_addr = lfsr_r;

  // Zero insertion stretches the sequence to every address, all zero included
  always_comb
  begin
    fb = (^(lfsr_r & TAPS[AW-1:0])) ^ (lfsr_r[AW-2:0] == '0);
    lfsr_nxt = lfsr_r;
    if (scan_req)
    begin
      lfsr_nxt = {lfsr_r[AW-2:0], fb}; // Pseudo-random visiting order
    end
  end

  // Address state
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      lfsr_r <= '0;
    end
    else
    begin
      lfsr_r <= lfsr_nxt;
    end
  end

endmodule

// ===== verilog/fmr_top.sv
// Fault monitor: sensors, parity, stack limits, watchdog, reset cause and exceptions
//
// Overview of operation
// - Out-of-range sensor forces reset or exception
// - Inverted correction mode raises exception on error
// - Parity checked on every RAM read
// - Idle-cycle scanner checks all RAM randomly
// - Any RAM parity error triggers security reset
// - Defined reset values; reset cause visible
// - Exception reason visible to software
// - Software cannot disable the sensors
// - Three stack pointers, one per privilege
// - Current privilege's stack outside its limits raises exception
// - High-voltage check sampled, no automatic event
// - Software switches double-read detection
// - Watchdog idle until software enables it
// - Disabled coprocessor use raises exception
// - ROM parity error also forces reset
//
// Our own choices: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/100ps
module fmr_top #(
  parameter int N_SENS = 4,
  parameter logic [31:0] SENS_RST_MASK = 32'h0000_0003,
  parameter int RAM_AW = 10,
  parameter int WDT_W = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // Sensors
  input wire logic [N_SENS-1:0] sensor_alarm,
  output logic [N_SENS-1:0] sensor_en,
  // Memories
  input wire fmr_pkg::fmr_mem_rd_type ram_rd,
  input wire logic cpu_ram_busy,
  output logic scan_req,
  output logic [RAM_AW-1:0] scan_addr,
  input wire fmr_pkg::fmr_mem_rd_type scan_rd,
  input wire fmr_pkg::fmr_mem_rd_type rom_rd,
  // Non-volatile memory
  input wire logic inv_ecc_en,
  input wire logic nvm_ecc_err,
  input wire logic nvm_dread_mismatch,
  output logic nvm_dread_en,
  input wire logic nvm_write_active,
  input wire logic hv_ok,
  // Core
  input wire fmr_pkg::fmr_priv_type cur_priv,
  input wire fmr_pkg::fmr_sp_wr_type sp_wr,
  input wire logic arith_disabled,
  input wire logic cipher_disabled,
  input wire logic arith_use,
  input wire logic cipher_use,
  // Responses
  output logic exc_irq,
  output logic sec_reset_req
);

  // ****************************************
  // Elaboration checks
  // ****************************************
  if (N_SENS < 1 || N_SENS > 32)
  begin : g_bad_sens
    $error("fmr_top: N_SENS must lie between 1 and 32");
  end
  if (WDT_W < 8 || WDT_W > 32)
  begin : g_bad_wdt
    $error("fmr_top: WDT_W must lie between 8 and 32");
  end

  localparam int NP = fmr_pkg::N_PRIV;

  // ****************************************
  // Declarations
  // ****************************************
  logic [N_SENS-1:0] sens_meta_r, sens_sync_r, sens_prev_r, sens_rise;
  logic hv_meta_r, hv_sync_r;
  logic wr_pend_r, wr_pend_nxt;
  logic [7:0] wr_addr_r, wr_addr_nxt;
  logic [31:0] hrdata_r, hrdata_nxt, rd_mux;
  logic [fmr_pkg::CTRL_W-1:0] ctrl_r, ctrl_nxt;
  logic [WDT_W-1:0] wdt_load_r, wdt_load_nxt, wdt_cnt_r, wdt_cnt_nxt;
  logic [fmr_pkg::EXC_W-1:0] exc_en_r, exc_en_nxt, exc_status_r, exc_status_nxt, exc_clr, ev;
  logic [fmr_pkg::CAUSE_W-1:0] cause_r, cause_nxt, rst_code;
  logic cause_unread_r, cause_unread_nxt, cause_clr, cause_rd;
  logic sec_rst_r, sec_rst_nxt;
  logic [fmr_pkg::HV_W-1:0] hv_status_r, hv_status_nxt;
  logic hv_prev_r, hv_acc_r, hv_acc_nxt;
  logic [fmr_pkg::SP_W-1:0] sp_r [NP], sp_nxt [NP], sp_lo_r [NP], sp_lo_nxt [NP];
  logic [fmr_pkg::SP_W-1:0] sp_hi_r [NP], sp_hi_nxt [NP];
  logic [NP-1:0] sp_viol;
  logic [fmr_pkg::MEM_PW-1:0] ram_err, scan_err, rom_err;
  logic rd_take, wdt_kick, wdt_expire, sens_rst_ev, sens_exc_ev;
  logic ram_bad, scan_bad, rom_bad;

  // ****************************************
  // Pin synchronisers
  // ****************************************
  // Sensors and the HV comparator are asynchronous to clk
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sens_meta_r <= '0;
      sens_sync_r <= '0;
      sens_prev_r <= '0;
      hv_meta_r <= 1'b0;
      hv_sync_r <= 1'b0;
    end
    else
    begin
      sens_meta_r <= sensor_alarm;
      sens_sync_r <= sens_meta_r;
      sens_prev_r <= sens_sync_r;
      hv_meta_r <= hv_ok;
      hv_sync_r <= hv_meta_r;
    end
  end

  // Edge only, so a held alarm fires one reset, not a stream
  assign sens_rise = sens_sync_r & ~sens_prev_r;
  assign sens_rst_ev = |(sens_rise & SENS_RST_MASK[N_SENS-1:0]);
  assign sens_exc_ev = |(sens_rise & ~SENS_RST_MASK[N_SENS-1:0]);
  assign sensor_en = '1; // Sensors always on, no writable enable

  // ****************************************
  // Parity checks and background scanner
  // ****************************************
  // Even parity, one bit per lane
  for (genvar p = 0; p < fmr_pkg::MEM_PW; p++)
  begin : g_par
    localparam int LW = fmr_pkg::MEM_LW;
    assign ram_err[p] = ^{ram_rd.data[p*LW +: LW], ram_rd.par[p]};
    assign scan_err[p] = ^{scan_rd.data[p*LW +: LW], scan_rd.par[p]};
    assign rom_err[p] = ^{rom_rd.data[p*LW +: LW], rom_rd.par[p]};
  end
  assign ram_bad = ram_rd.valid && |ram_err;
  assign scan_bad = scan_rd.valid && |scan_err;
  assign rom_bad = rom_rd.valid && |rom_err;

  fmr_scan #(
    .AW(RAM_AW)
  ) u_scan (
    .clk(clk),
    .resetn(resetn),
    .cpu_ram_busy(cpu_ram_busy),
    .scan_req(scan_req),
    .scan_addr(scan_addr)
  );

  // ****************************************
  // Stack pointers and limit checks
  // ****************************************
  // One pointer and one pair of limits per privilege level
  for (genvar i = 0; i < NP; i++)
  begin : g_sp
    always_comb
    begin
      sp_nxt[i] = sp_r[i];
      if (sp_wr.valid && sp_wr.priv == fmr_pkg::fmr_priv_type'(i))
      begin
        sp_nxt[i] = sp_wr.value;
      end
    end
    // Level check also catches limits tightened under a live pointer
    assign sp_viol[i] = (cur_priv == fmr_pkg::fmr_priv_type'(i)) &&
                        (sp_r[i] < sp_lo_r[i] || sp_r[i] > sp_hi_r[i]);
  end

  // ****************************************
  // AHB-Lite register access
  // ****************************************
  assign rd_take = hsel && htrans[1] && hready && !hwrite;
  assign cause_rd = rd_take && haddr[7:0] == fmr_pkg::REG_RST_CAUSE;

  // Read mux sampled in the address phase, driven from a flop in the data phase
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    case (haddr[7:0])
      fmr_pkg::REG_CTRL: rd_mux[fmr_pkg::CTRL_W-1:0] = ctrl_r;
      fmr_pkg::REG_WDT_LOAD: rd_mux[WDT_W-1:0] = wdt_load_r;
      fmr_pkg::REG_RST_CAUSE: rd_mux[fmr_pkg::CAUSE_W-1:0] = cause_r;
      fmr_pkg::REG_EXC_STATUS: rd_mux[fmr_pkg::EXC_W-1:0] = exc_status_r;
      fmr_pkg::REG_EXC_ENABLE: rd_mux[fmr_pkg::EXC_W-1:0] = exc_en_r;
      fmr_pkg::REG_HV_STATUS: rd_mux[fmr_pkg::HV_W-1:0] = hv_status_r;
      fmr_pkg::REG_SENS_EN: rd_mux[N_SENS-1:0] = sensor_en;
      default:
      begin
        for (int i = 0; i < NP; i++)
        begin
          if (haddr[7:0] == 8'(fmr_pkg::REG_SP_BASE + fmr_pkg::REG_SP_STEP * i))
          begin
            rd_mux[fmr_pkg::SP_W-1:0] = sp_lo_r[i];
          end
          if (haddr[7:0] == 8'(fmr_pkg::REG_SP_BASE + fmr_pkg::REG_SP_STEP * i + fmr_pkg::REG_SP_HI))
          begin
            rd_mux[fmr_pkg::SP_W-1:0] = sp_hi_r[i];
          end
        end
      end
    endcase
  end

  // Write decode in the data phase; unmapped writes fall away
  always_comb
  begin
    wr_pend_nxt = hsel && htrans[1] && hready && hwrite;
    wr_addr_nxt = wr_pend_nxt ? haddr[7:0] : wr_addr_r;
    hrdata_nxt = rd_take ? rd_mux : hrdata_r;
    ctrl_nxt = ctrl_r;
    wdt_load_nxt = wdt_load_r;
    exc_en_nxt = exc_en_r;
    sp_lo_nxt = sp_lo_r;
    sp_hi_nxt = sp_hi_r;
    exc_clr = '0;
    cause_clr = 1'b0;
    wdt_kick = 1'b0;
    if (wr_pend_r)
    begin
      case (wr_addr_r)
        fmr_pkg::REG_CTRL: ctrl_nxt = hwdata[fmr_pkg::CTRL_W-1:0];
        fmr_pkg::REG_WDT_LOAD: wdt_load_nxt = hwdata[WDT_W-1:0];
        fmr_pkg::REG_WDT_KICK: wdt_kick = 1'b1;
        fmr_pkg::REG_RST_CAUSE: cause_clr = 1'b1;
        fmr_pkg::REG_EXC_CLEAR: exc_clr = hwdata[fmr_pkg::EXC_W-1:0];
        fmr_pkg::REG_EXC_ENABLE: exc_en_nxt = hwdata[fmr_pkg::EXC_W-1:0];
        fmr_pkg::REG_SENS_EN: ; // Write dropped on purpose
        default:
        begin
          for (int i = 0; i < NP; i++)
          begin
            if (wr_addr_r == 8'(fmr_pkg::REG_SP_BASE + fmr_pkg::REG_SP_STEP * i))
            begin
              sp_lo_nxt[i] = hwdata[fmr_pkg::SP_W-1:0];
            end
            if (wr_addr_r == 8'(fmr_pkg::REG_SP_BASE + fmr_pkg::REG_SP_STEP * i + fmr_pkg::REG_SP_HI))
            begin
              sp_hi_nxt[i] = hwdata[fmr_pkg::SP_W-1:0];
            end
          end
        end
      endcase
    end
  end

  assign hreadyout = 1'b1; // Zero wait states
  assign hresp = 1'b0; // Always OKAY
  assign hrdata = hrdata_r;
  assign nvm_dread_en = ctrl_r[fmr_pkg::CTRL_DREAD_BIT];

  // ****************************************
  // Watchdog
  // ****************************************
  // Disabled counter sits at the load value, so enabling starts a full period
  always_comb
  begin
    wdt_expire = 1'b0;
    wdt_cnt_nxt = wdt_cnt_r;
    if (!ctrl_r[fmr_pkg::CTRL_WDT_EN_BIT] || wdt_kick)
    begin
      wdt_cnt_nxt = wdt_load_r;
    end
    else if (wdt_cnt_r == '0)
    begin
      wdt_expire = 1'b1;
      wdt_cnt_nxt = wdt_load_r;
    end
    else
    begin
      wdt_cnt_nxt = wdt_cnt_r - 1'b1;
    end
  end

  // ****************************************
  // High-voltage check during NVM writes
  // ****************************************
  // Result only lands in a register; nothing else reacts to it
  always_comb
  begin
    hv_acc_nxt = hv_acc_r;
    hv_status_nxt = hv_status_r;
    if (nvm_write_active)
    begin
      hv_acc_nxt = (hv_prev_r ? hv_acc_r : 1'b1) & hv_sync_r;
    end
    else if (hv_prev_r)
    begin
      hv_status_nxt[fmr_pkg::HV_VALID_BIT] = 1'b1;
      hv_status_nxt[fmr_pkg::HV_OK_BIT] = hv_acc_r;
    end
  end

  // ****************************************
  // Exceptions, reset requests and reset cause
  // ****************************************
  always_comb
  begin
    ev = '0;
    ev[fmr_pkg::EXC_SENSOR] = sens_exc_ev;
    ev[fmr_pkg::EXC_NVM_ECC] = nvm_ecc_err && inv_ecc_en;
    ev[fmr_pkg::EXC_STACK0 +: NP] = sp_viol;
    ev[fmr_pkg::EXC_ARITH] = arith_use && arith_disabled;
    ev[fmr_pkg::EXC_CIPHER] = cipher_use && cipher_disabled;
    ev[fmr_pkg::EXC_WDT] = wdt_expire && !ctrl_r[fmr_pkg::CTRL_WDT_RST_BIT];
    ev[fmr_pkg::EXC_DREAD] = nvm_dread_mismatch && ctrl_r[fmr_pkg::CTRL_DREAD_BIT];
    // Set wins over a clear in the same cycle
    exc_status_nxt = (exc_status_r & ~exc_clr) | ev;
    // Highest priority source names the cause when several coincide
    rst_code = fmr_pkg::CAUSE_NONE;
    if (sens_rst_ev)
      rst_code = fmr_pkg::CAUSE_SENSOR;
    else if (ram_bad)
      rst_code = fmr_pkg::CAUSE_RAM_PAR;
    else if (scan_bad)
      rst_code = fmr_pkg::CAUSE_SCAN_PAR;
    else if (rom_bad)
      rst_code = fmr_pkg::CAUSE_ROM_PAR;
    else if (wdt_expire && ctrl_r[fmr_pkg::CTRL_WDT_RST_BIT])
      rst_code = fmr_pkg::CAUSE_WDT;
    sec_rst_nxt = rst_code != fmr_pkg::CAUSE_NONE;
    cause_nxt = cause_clr ? fmr_pkg::CAUSE_NONE : cause_r;
    cause_unread_nxt = (cause_unread_r && !cause_rd && !cause_clr);
    // An unread cause is never replaced
    if (sec_rst_nxt && !cause_unread_nxt)
    begin
      cause_nxt = rst_code;
      cause_unread_nxt = 1'b1;
    end
  end

  assign exc_irq = |(exc_status_r & exc_en_r);
  assign sec_reset_req = sec_rst_r;

  // ****************************************
  // State registers
  // ****************************************
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= '0;
      hrdata_r <= '0;
      ctrl_r <= fmr_pkg::CTRL_RST;
      wdt_load_r <= WDT_W'(fmr_pkg::WDT_LOAD_RST);
      wdt_cnt_r <= WDT_W'(fmr_pkg::WDT_LOAD_RST);
      exc_en_r <= '0;
      exc_status_r <= '0;
      cause_r <= fmr_pkg::CAUSE_POWERON;
      cause_unread_r <= 1'b1;
      sec_rst_r <= 1'b0;
      hv_status_r <= '0;
      hv_prev_r <= 1'b0;
      hv_acc_r <= 1'b0;
      for (int i = 0; i < NP; i++)
      begin
        sp_r[i] <= fmr_pkg::SP_LO_RST;
        sp_lo_r[i] <= fmr_pkg::SP_LO_RST;
        sp_hi_r[i] <= fmr_pkg::SP_HI_RST;
      end
    end
    else
    begin
      wr_pend_r <= wr_pend_nxt;
      wr_addr_r <= wr_addr_nxt;
      hrdata_r <= hrdata_nxt;
      ctrl_r <= ctrl_nxt;
      wdt_load_r <= wdt_load_nxt;
      wdt_cnt_r <= wdt_cnt_nxt;
      exc_en_r <= exc_en_nxt;
      exc_status_r <= exc_status_nxt;
      cause_r <= cause_nxt;
      cause_unread_r <= cause_unread_nxt;
      sec_rst_r <= sec_rst_nxt;
      hv_status_r <= hv_status_nxt;
      hv_prev_r <= nvm_write_active;
      hv_acc_r <= hv_acc_nxt;
      sp_r <= sp_nxt;
      sp_lo_r <= sp_lo_nxt;
      sp_hi_r <= sp_hi_nxt;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  sensor_reset_a: assert property (sens_rst_ev |=> sec_reset_req)
    else $error("reset-class sensor alarm did not request reset");
  inv_ecc_a: assert property (nvm_ecc_err && inv_ecc_en |=> exc_status_r[fmr_pkg::EXC_NVM_ECC])
    else $error("correction error not raised as exception");
  ram_parity_a: assert property (ram_bad |=> sec_reset_req && cause_r != fmr_pkg::CAUSE_NONE)
    else $error("RAM read parity error without reset");
  scan_idle_a: assert property (cpu_ram_busy |-> !scan_req ##1 $stable(scan_addr))
    else $error("scanner used a software RAM cycle");
  scan_parity_a: assert property (scan_bad |=> sec_reset_req)
    else $error("scanner parity error without reset");
  rom_parity_a: assert property (rom_bad |=> sec_reset_req)
    else $error("ROM parity error without reset");
  cause_hold_a: assert property (cause_unread_r && !cause_rd && !cause_clr |=> $stable(cause_r))
    else $error("unread reset cause overwritten");
  copro_a: assert property (arith_use && arith_disabled |=> exc_status_r[fmr_pkg::EXC_ARITH])
    else $error("disabled coprocessor use not trapped");
  stack_a: assert property (|sp_viol |=> (exc_status_r[fmr_pkg::EXC_STACK0 +: NP] & $past(sp_viol)) != '0)
    else $error("stack limit violation not raised");
  wdt_idle_a: assert property (!ctrl_r[fmr_pkg::CTRL_WDT_EN_BIT] |-> !wdt_expire ##1 wdt_cnt_r == $past(wdt_load_r))
    else $error("watchdog fired while disabled");
  hv_sample_a: assert property ($fell(nvm_write_active) |=> hv_status_r[fmr_pkg::HV_VALID_BIT])
    else $error("HV check not sampled at end of write");

endmodule

// ===== sim/tb.sv
// Self-checking bench of the fault monitor
`timescale 1ns/100ps
module tb;
  // ****************************************
  // Stimulus and observed signals
  // ****************************************
  logic clk = 0, resetn = 0, hsel = 1, hwrite = 0, hready;
  logic [31:0] haddr = 0, hwdata = 0, hrdata;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 3'h2;
  logic [3:0] sensor_alarm = 0, sensor_en;
  logic hreadyout, hresp, cpu_ram_busy = 0, scan_req, inv_ecc_en = 0, nvm_ecc_err = 0;
  logic nvm_dread_mismatch = 0, nvm_dread_en, nvm_write_active = 0, hv_ok = 0, exc_irq, sec_reset_req;
  logic arith_disabled = 0, cipher_disabled = 0, arith_use = 0, cipher_use = 0, rd_dp = 0;
  logic [9:0] scan_addr, last_addr = '0;
  logic last_busy = 0;
  fmr_pkg::fmr_mem_rd_type ram_rd = '0, scan_rd = '0, rom_rd = '0;
  fmr_pkg::fmr_priv_type cur_priv = fmr_pkg::PRIV_USER;
  fmr_pkg::fmr_sp_wr_type sp_wr = '0;
  logic [31:0] expq[$];
  int failures = 0, n_compared = 0, seed = 87404, bad_sel = 0;

  assign hready = hreadyout;
  fmr_top u_fmr_top (.clk(clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .sensor_alarm(sensor_alarm), .sensor_en(sensor_en),
    .ram_rd(ram_rd), .cpu_ram_busy(cpu_ram_busy), .scan_req(scan_req), .scan_addr(scan_addr),
    .scan_rd(scan_rd), .rom_rd(rom_rd), .inv_ecc_en(inv_ecc_en), .nvm_ecc_err(nvm_ecc_err),
    .nvm_dread_mismatch(nvm_dread_mismatch), .nvm_dread_en(nvm_dread_en),
    .nvm_write_active(nvm_write_active), .hv_ok(hv_ok), .cur_priv(cur_priv), .sp_wr(sp_wr),
    .arith_disabled(arith_disabled), .cipher_disabled(cipher_disabled), .arith_use(arith_use),
    .cipher_use(cipher_use), .exc_irq(exc_irq), .sec_reset_req(sec_reset_req));

  // Clock of 100 ns
  always #50 clk = ~clk;

  // ****************************************
  // Helpers
  // ****************************************
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic give_verdict;
    if (failures == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Memory word with even lane parity, lane 0 flipped when bad
  function automatic fmr_pkg::fmr_mem_rd_type mk(input logic v, input logic bad, input logic [31:0] d);
    mk.valid = v;
    mk.data = d;
    for (int p = 0; p < fmr_pkg::MEM_PW; p++)
      mk.par[p] = ^d[8*p +: 8];
    mk.par[0] = mk.par[0] ^ bad;
  endfunction

  // One single AHB transfer; waits for hready in both phases
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    expq.push_back(e);
    ahb(1'b0, a, 32'h0);
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic irq(input logic e);
    @(negedge clk);
    check("exc_irq", {31'h0, exc_irq}, {31'h0, e});
  endtask

  // Bounded wait for the reset request pulse
  task automatic want_reset;
    int k;
    k = 0;
    while (sec_reset_req !== 1'b1 && k < 8)
    begin
      @(negedge clk);
      k++;
    end
    check("sec_reset_req", {31'h0, sec_reset_req}, 32'h1);
  endtask

  task automatic pulse_all;
    @(posedge clk);
    {nvm_ecc_err, nvm_dread_mismatch, arith_use, cipher_use} <= 4'hF;
    @(posedge clk);
    {nvm_ecc_err, nvm_dread_mismatch, arith_use, cipher_use} <= 4'h0;
  endtask

  // ****************************************
  // Background memory traffic and observer
  // ****************************************
  always @(posedge clk)
  begin
    cpu_ram_busy <= $random(seed);
    ram_rd <= mk(cpu_ram_busy | (bad_sel == 1), bad_sel == 1, $random(seed));
    scan_rd <= mk(scan_req | (bad_sel == 2), bad_sel == 2, $random(seed));
    rom_rd <= mk(1'b1, bad_sel == 3, $random(seed));
  end

  // Read data compared against the oldest expectation
  always @(posedge clk)
  begin
    if (rd_dp && hreadyout === 1'b1)
      check("hrdata", hrdata, expq.pop_front());
    if (hreadyout === 1'b1)
      rd_dp <= resetn && htrans[1] && !hwrite;
  end

  // Scanner only runs while software leaves the RAM alone
  // Scan address must not move across a busy cycle
  always @(negedge clk)
  begin
    if (resetn)
    begin
      check("scan_req", {31'h0, scan_req}, {31'h0, !cpu_ram_busy});
      check("hresp", {31'h0, hresp}, 32'h0);
      if (last_busy)
        check("scan_addr", {22'h0, scan_addr}, {22'h0, last_addr});
    end
    last_busy <= resetn && cpu_ram_busy;
    last_addr <= scan_addr;
  end

  initial
  begin
    #2000000;
    failures++;
    give_verdict();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    tick(3);
    resetn <= 1;
    rd(fmr_pkg::REG_RST_CAUSE, 32'h1);
    rd(fmr_pkg::REG_SP_BASE + 8'h14, 32'hFFFF);
    rd(fmr_pkg::REG_EXC_ENABLE, 32'h0);
    ahb(1'b1, fmr_pkg::REG_SENS_EN, 32'h0);
    rd(fmr_pkg::REG_SENS_EN, 32'hF);
    check("sensor_en", {28'h0, sensor_en}, 32'hF);
    // Options off: every event is refused
    pulse_all();
    rd(fmr_pkg::REG_EXC_STATUS, 32'h0);
    inv_ecc_en <= 1;
    arith_disabled <= 1;
    cipher_disabled <= 1;
    ahb(1'b1, fmr_pkg::REG_CTRL, 32'h1);
    @(negedge clk);
    check("nvm_dread_en", {31'h0, nvm_dread_en}, 32'h1);
    pulse_all();
    sensor_alarm <= 4'h4;
    tick(3);
    sensor_alarm <= 4'h0;
    tick(4);
    rd(fmr_pkg::REG_EXC_STATUS, 32'h163);
    irq(1'b0);
    ahb(1'b1, fmr_pkg::REG_EXC_ENABLE, 32'h1FF);
    irq(1'b1);
    ahb(1'b1, fmr_pkg::REG_EXC_CLEAR, 32'h1FF);
    rd(fmr_pkg::REG_EXC_STATUS, 32'h0);
    irq(1'b0);
    // Parity errors of RAM read, scanner and ROM
    for (int k = 1; k <= 3; k++)
    begin
      @(posedge clk);
      bad_sel <= k;
      @(posedge clk);
      bad_sel <= 0;
      want_reset();
      rd(fmr_pkg::REG_RST_CAUSE, 32'h2 + k);
    end
    // Unread cause is not overwritten by a later event
    ahb(1'b1, fmr_pkg::REG_RST_CAUSE, 32'h0);
    tick(1);
    bad_sel <= 1;
    tick(1);
    bad_sel <= 3;
    tick(1);
    bad_sel <= 0;
    tick(3);
    rd(fmr_pkg::REG_RST_CAUSE, 32'h3);
    sensor_alarm <= 4'h1;
    tick(2);
    sensor_alarm <= 4'h0;
    want_reset();
    rd(fmr_pkg::REG_RST_CAUSE, 32'h2);
    // High-voltage check of a write sequence
    hv_ok <= 1;
    tick(4);
    nvm_write_active <= 1;
    tick(5);
    nvm_write_active <= 0;
    tick(4);
    rd(fmr_pkg::REG_HV_STATUS, 32'h3);
    irq(1'b0);
    // Watchdog stays idle until enabled
    ahb(1'b1, fmr_pkg::REG_WDT_LOAD, 32'h5);
    tick(12);
    rd(fmr_pkg::REG_EXC_STATUS, 32'h0);
    ahb(1'b1, fmr_pkg::REG_CTRL, 32'h3);
    tick(12);
    ahb(1'b1, fmr_pkg::REG_CTRL, 32'h1);
    rd(fmr_pkg::REG_EXC_STATUS, 32'h80);
    ahb(1'b1, fmr_pkg::REG_EXC_CLEAR, 32'h1FF);
    // Watchdog in reset mode names its own cause
    ahb(1'b1, fmr_pkg::REG_CTRL, 32'h7);
    want_reset();
    ahb(1'b1, fmr_pkg::REG_CTRL, 32'h1);
    rd(fmr_pkg::REG_RST_CAUSE, 32'h6);
    // User stack inside, then below its lower limit
    @(posedge clk);
    sp_wr <= '{1'b1, fmr_pkg::PRIV_USER, 16'h0300};
    @(posedge clk);
    sp_wr.valid <= 0;
    ahb(1'b1, fmr_pkg::REG_SP_BASE, 32'h200);
    rd(fmr_pkg::REG_EXC_STATUS, 32'h0);
    @(posedge clk);
    sp_wr <= '{1'b1, fmr_pkg::PRIV_USER, 16'h0100};
    @(posedge clk);
    sp_wr.valid <= 0;
    tick(2);
    rd(fmr_pkg::REG_EXC_STATUS, 32'h4);
    irq(1'b1);
    rd(8'h80, 32'h0);
    tick(2);
    give_verdict();
  end
endmodule
